/* hdl/flash_status_pkg.sv */
// Constants shared by the status register and protection decode logic.
package flash_status_pkg;

  // ---------------------------------------------------------------------
  // Status bit positions (low byte S7..S0, high byte S15..S8)
  // ---------------------------------------------------------------------
  localparam int unsigned BIT_BUSY      = 0;
  localparam int unsigned BIT_WEL       = 1;
  localparam int unsigned BIT_RANGE_LO  = 2;
  localparam int unsigned BIT_RANGE_HI  = 4;
  localparam int unsigned BIT_TOP_BOT   = 5;
  localparam int unsigned BIT_SMALL     = 6;
  localparam int unsigned BIT_GUARD_LO  = 7;
  localparam int unsigned BIT_GUARD_HI  = 8;
  localparam int unsigned BIT_QUAD      = 9;
  localparam int unsigned BIT_LOCK_1    = 11;
  localparam int unsigned BIT_LOCK_3    = 13;
  localparam int unsigned BIT_CMP       = 14;
  localparam int unsigned BIT_PAUSED    = 15;

  // Non-volatile bits and the one-time lock bits inside them.
  localparam logic [15:0] NV_MASK       = 16'h7BFC;
  localparam logic [15:0] LOCK_MASK     = 16'h3800;
  localparam logic [15:0] STATUS_RESET  = 16'h0000;

  // ---------------------------------------------------------------------
  // Instruction codes
  // ---------------------------------------------------------------------
  localparam logic [7:0] CMD_WREN       = 8'h06;
  localparam logic [7:0] CMD_WRDI       = 8'h04;
  localparam logic [7:0] CMD_WRSR       = 8'h01;
  localparam logic [7:0] CMD_PAGE_PROG  = 8'h02;
  localparam logic [7:0] CMD_QUAD_PROG  = 8'h32;
  localparam logic [7:0] CMD_ERASE_4K   = 8'h20;
  localparam logic [7:0] CMD_ERASE_32K  = 8'h52;
  localparam logic [7:0] CMD_ERASE_64K  = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ER_A  = 8'hC7;
  localparam logic [7:0] CMD_CHIP_ER_B  = 8'h60;
  localparam logic [7:0] CMD_SUSPEND    = 8'h75;
  localparam logic [7:0] CMD_RESUME     = 8'h7A;
  localparam logic [7:0] CMD_SEC_ERASE  = 8'h44;
  localparam logic [7:0] CMD_SEC_PROG   = 8'h42;

  // ---------------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W        = 23;
  localparam logic [23:0] ARRAY_BYTES   = 24'h80_0000;
  localparam logic [23:0] SECTOR_BYTES  = 24'h00_1000;
  localparam logic [23:0] BLOCK_BYTES   = 24'h01_0000;
  localparam logic [22:0] PAGE_MASK     = 23'h00_00FF;
  localparam logic [22:0] SECTOR_MASK   = 23'h00_0FFF;
  localparam logic [22:0] BLK32_MASK    = 23'h00_7FFF;
  localparam logic [22:0] BLK64_MASK    = 23'h00_FFFF;
  localparam logic [22:0] ARRAY_MASK    = 23'h7F_FFFF;

  // Guard modes held in status_guard_hi, status_guard_lo.
  typedef enum logic [1:0] {
    GUARD_SOFT     = 2'h0,
    GUARD_HARDWARE = 2'h1,
    GUARD_LOCKDOWN = 2'h2,
    GUARD_OTP      = 2'h3
  } guard_mode_type;

endpackage : flash_status_pkg

/* hdl/protect_range_decode.sv */
// Decode of the protection bits into one protected address range.
`timescale 1ns/1ps
`default_nettype none

module protect_range_decode
  import flash_status_pkg::*;
(
  input  wire logic [2:0]  range_sel_in,
  input  wire logic        top_bottom_in,
  input  wire logic        small_unit_in,
  input  wire logic        complement_in,
  output logic             prot_any_out,
  output logic [22:0]      prot_lo_out,
  output logic [22:0]      prot_hi_out
);

  logic [23:0] size_bytes;
  logic [1:0]  sec_shift;
  logic        sel_none;
  logic        sel_all;

  // ---------------------------------------------------------------------
  // Size of the base region
  // ---------------------------------------------------------------------
  always_comb begin
    sel_none  = (range_sel_in == 3'h0);
    sel_all   = (range_sel_in == 3'h7);
    sec_shift = (range_sel_in[2]) ? 2'h3 : 2'(range_sel_in[1:0] - 2'h1);
    if (small_unit_in) begin
      size_bytes = SECTOR_BYTES << sec_shift;
    end else begin
      size_bytes = BLOCK_BYTES << range_sel_in;
    end
  end

  // ---------------------------------------------------------------------
  // Region placement and complement
  // ---------------------------------------------------------------------
  always_comb begin
    prot_any_out = 1'b0;
    prot_lo_out  = 23'h0;
    prot_hi_out  = ARRAY_MASK;
    if (sel_none || sel_all) begin
      prot_any_out = sel_all ^ complement_in;
    end else if (!complement_in) begin
      prot_any_out = 1'b1;
      if (!top_bottom_in) begin
        prot_lo_out = 23'(ARRAY_BYTES - size_bytes);
      end else begin
        prot_hi_out = 23'(size_bytes - 24'h1);
      end
    end else begin
      prot_any_out = 1'b1;
      if (!top_bottom_in) begin
        prot_hi_out = 23'(ARRAY_BYTES - size_bytes - 24'h1);
      end else begin
        prot_lo_out = 23'(size_bytes);
      end
    end
  end

endmodule // protect_range_decode

`default_nettype wire

/* hdl/flash_status_write_protect.sv */
// Status register, write-enable latch and array protection of the flash.
//
// Functional notes
// - Write Enable sets the write latch.
// - Latch clears after disable, program, erase, status write.
// - Range-select bits non-volatile, default nothing protected.
// - top_bottom picks top or bottom placement.
// - small_unit_select picks 4 kB or 64 kB.
// - complement_flag swaps protected and unprotected regions.
// - Block mode sizes 128 kB doubling to 4 MB.
// - Sector mode sizes 4, 8, 16, 32 kB.
// - Two guard bits choose status write protection.
// - Guard 00: pin ignored, latch alone enables.
// - Guard 01: pin low refuses status writes.
// - Guard 01, pin high: latch enables writes.
// - Guard 10 locks until power cycle, then 00.
// - Guard 11 refuses status writes permanently.
// - Suspend sets paused flag, resume clears it.
// - Lock bits set-only, make security register read-only.
// - quad_enable turns the guard pin into data.
// - Program or erase touching protection is ignored.
// - Busy bit set while a write operation runs.
`timescale 1ns/1ps
`default_nettype none

module flash_status_write_protect
  import flash_status_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] nv_image_in,
  input  wire logic        cmd_valid_in,
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic [23:0] cmd_addr_in,
  input  wire logic [15:0] cmd_wdata_in,
  input  wire logic        op_done_in,
  input  wire logic        write_protect_n_in,
  output logic [7:0]       status_low_byte_out,
  output logic [7:0]       status_high_byte_out,
  output logic             op_start_out,
  output logic             cmd_refused_out,
  output logic             nv_write_out,
  output logic [15:0]      nv_data_out,
  output logic             quad_mode_out,
  output logic             prot_any_out,
  output logic [22:0]      prot_lo_out,
  output logic [22:0]      prot_hi_out
);

  typedef enum logic [1:0] {
    LOAD_WAIT = 2'b01,
    LOAD_DONE = 2'b10
  } load_state_type;

  load_state_type load_r;
  load_state_type load_nxt;
  logic [15:0]    stat_r;
  logic [15:0]    stat_nxt;
  logic           op_start_nxt;
  logic           refused_nxt;
  logic           nv_write_nxt;
  logic [15:0]    nv_data_nxt;
  logic           dec_any;
  logic [22:0]    dec_lo;
  logic [22:0]    dec_hi;
  logic [22:0]    tgt_lo;
  logic [22:0]    tgt_hi;
  logic [22:0]    tgt_mask;
  logic           is_array_op;
  logic           is_sec_op;
  logic           hits_prot;
  logic           sec_locked;
  logic           guard_ok;
  logic           pin_high;
  logic           take;
  guard_mode_type guard;

  // ---------------------------------------------------------------------
  // Protection decode
  // ---------------------------------------------------------------------
  protect_range_decode u_decode (
    .range_sel_in  (stat_r[BIT_RANGE_HI:BIT_RANGE_LO]),
    .top_bottom_in (stat_r[BIT_TOP_BOT]),
    .small_unit_in (stat_r[BIT_SMALL]),
    .complement_in (stat_r[BIT_CMP]),
    .prot_any_out  (dec_any),
    .prot_lo_out   (dec_lo),
    .prot_hi_out   (dec_hi)
  );

  // ---------------------------------------------------------------------
  // Command classification
  // ---------------------------------------------------------------------
  always_comb begin
    guard       = guard_mode_type'({stat_r[BIT_GUARD_HI],
                                    stat_r[BIT_GUARD_LO]});
    // With quad mode on, the guard pin is a data line and reads as high.
    pin_high    = write_protect_n_in || stat_r[BIT_QUAD];
    is_array_op = 1'b1;
    tgt_mask    = PAGE_MASK;
    case (cmd_code_in)
      CMD_PAGE_PROG,
      CMD_QUAD_PROG: tgt_mask = PAGE_MASK;
      CMD_ERASE_4K:  tgt_mask = SECTOR_MASK;
      CMD_ERASE_32K: tgt_mask = BLK32_MASK;
      CMD_ERASE_64K: tgt_mask = BLK64_MASK;
      CMD_CHIP_ER_A,
      CMD_CHIP_ER_B: tgt_mask = ARRAY_MASK;
      default:       is_array_op = 1'b0;
    endcase
    tgt_lo     = cmd_addr_in[22:0] & ~tgt_mask;
    tgt_hi     = cmd_addr_in[22:0] | tgt_mask;
    hits_prot  = dec_any && (tgt_lo <= dec_hi) && (tgt_hi >= dec_lo);
    is_sec_op  = (cmd_code_in == CMD_SEC_ERASE) ||
                 (cmd_code_in == CMD_SEC_PROG);
    case (cmd_addr_in[13:12])
      2'h1:    sec_locked = stat_r[BIT_LOCK_1];
      2'h2:    sec_locked = stat_r[BIT_LOCK_1 + 1];
      2'h3:    sec_locked = stat_r[BIT_LOCK_3];
      default: sec_locked = 1'b1;
    endcase
    case (guard)
      GUARD_SOFT:     guard_ok = 1'b1;
      GUARD_HARDWARE: guard_ok = pin_high;
      GUARD_LOCKDOWN: guard_ok = 1'b0;
      GUARD_OTP:      guard_ok = 1'b0;
      default:        guard_ok = 1'b0;
    endcase
    take = cmd_valid_in && (load_r == LOAD_DONE);
  end

  // ---------------------------------------------------------------------
  // Status next state
  // ---------------------------------------------------------------------
  always_comb begin
    load_nxt     = load_r;
    stat_nxt     = stat_r;
    op_start_nxt = 1'b0;
    refused_nxt  = 1'b0;
    nv_write_nxt = 1'b0;
    nv_data_nxt  = nv_data_out;
    case (load_r)
      LOAD_WAIT: begin
        // Non-volatile image is taken once after reset; lock-down reverts.
        stat_nxt = nv_image_in & NV_MASK;
        if ((nv_image_in[BIT_GUARD_HI]) && !(nv_image_in[BIT_GUARD_LO])) begin
          stat_nxt[BIT_GUARD_HI] = 1'b0;
        end
        load_nxt = LOAD_DONE;
      end
      LOAD_DONE: begin
        if (stat_r[BIT_BUSY]) begin
          if (op_done_in) begin
            stat_nxt[BIT_BUSY] = 1'b0;
          end
          if (take && (cmd_code_in == CMD_SUSPEND)) begin
            stat_nxt[BIT_PAUSED] = 1'b1;
            stat_nxt[BIT_BUSY]   = 1'b0;
          end
        end else if (take) begin
          case (cmd_code_in)
            CMD_WREN: stat_nxt[BIT_WEL] = 1'b1;
            CMD_WRDI: stat_nxt[BIT_WEL] = 1'b0;
            CMD_RESUME: begin
              if (stat_r[BIT_PAUSED]) begin
                stat_nxt[BIT_PAUSED] = 1'b0;
                stat_nxt[BIT_BUSY]   = 1'b1;
              end
            end
            CMD_WRSR: begin
              if (stat_r[BIT_WEL] && guard_ok) begin
                stat_nxt = (cmd_wdata_in & NV_MASK & ~LOCK_MASK) |
                           ((stat_r | cmd_wdata_in) & LOCK_MASK) |
                           (stat_r & ~NV_MASK);
                stat_nxt[BIT_WEL]  = 1'b0;
                stat_nxt[BIT_BUSY] = 1'b1;
                nv_write_nxt       = 1'b1;
                nv_data_nxt        = stat_nxt & NV_MASK;
              end else begin
                refused_nxt = 1'b1;
              end
            end
            default: begin
              if (is_array_op || is_sec_op) begin
                if (stat_r[BIT_WEL] && !stat_r[BIT_PAUSED] &&
                    !(is_array_op && hits_prot) &&
                    !(is_sec_op && sec_locked)) begin
                  stat_nxt[BIT_WEL]  = 1'b0;
                  stat_nxt[BIT_BUSY] = 1'b1;
                  op_start_nxt       = 1'b1;
                end else begin
                  refused_nxt = 1'b1;
                end
              end
            end
          endcase
        end
      end
      default: load_nxt = LOAD_WAIT;
    endcase
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      load_r               <= LOAD_WAIT;
      stat_r               <= STATUS_RESET;
      status_low_byte_out  <= 8'h00;
      status_high_byte_out <= 8'h00;
      op_start_out         <= 1'b0;
      cmd_refused_out      <= 1'b0;
      nv_write_out         <= 1'b0;
      nv_data_out          <= 16'h0000;
      quad_mode_out        <= 1'b0;
      prot_any_out         <= 1'b0;
      prot_lo_out          <= 23'h0;
      prot_hi_out          <= 23'h0;
    end else begin
      load_r               <= load_nxt;
      stat_r               <= stat_nxt;
      status_low_byte_out  <= stat_nxt[7:0];
      status_high_byte_out <= stat_nxt[15:8];
      op_start_out         <= op_start_nxt;
      cmd_refused_out      <= refused_nxt;
      nv_write_out         <= nv_write_nxt;
      nv_data_out          <= nv_data_nxt;
      quad_mode_out        <= stat_nxt[BIT_QUAD];
      prot_any_out         <= dec_any;
      prot_lo_out          <= dec_lo;
      prot_hi_out          <= dec_hi;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  logic idle_take;
  assign idle_take = take && !stat_r[BIT_BUSY];

  sequence s_wsr_try;
    idle_take && (cmd_code_in == CMD_WRSR);
  endsequence

  sequence s_wsr_blocked;
    s_wsr_try ##0 (!stat_r[BIT_WEL] || !guard_ok);
  endsequence

  property p_wel_set;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      idle_take && (cmd_code_in == CMD_WREN)
      |=> stat_r[BIT_WEL] && status_low_byte_out[BIT_WEL];
  endproperty
  a_wel_set: assert property (p_wel_set)
    else $error("write latch not set after write enable");

  property p_wel_clear;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      idle_take && (cmd_code_in == CMD_WRDI || op_start_nxt)
      |=> !stat_r[BIT_WEL];
  endproperty
  a_wel_clear: assert property (p_wel_clear)
    else $error("write latch not cleared");

  property p_refused_stable;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wsr_blocked |=> cmd_refused_out && !nv_write_out &&
                        (stat_r == $past(stat_r));
  endproperty
  a_refused_stable: assert property (p_refused_stable)
    else $error("refused status write changed status");

  property p_hw_guard;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wsr_try ##0 (guard == GUARD_HARDWARE) && !write_protect_n_in &&
      !stat_r[BIT_QUAD] |=> cmd_refused_out;
  endproperty
  a_hw_guard: assert property (p_hw_guard)
    else $error("status write accepted with guard pin low");

  property p_lock_guard;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wsr_try ##0 stat_r[BIT_GUARD_HI] |=> cmd_refused_out ##1 !nv_write_out;
  endproperty
  a_lock_guard: assert property (p_lock_guard)
    else $error("status write accepted under lock-down");

  property p_soft_accept;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wsr_try ##0 (guard == GUARD_SOFT) && stat_r[BIT_WEL]
      |=> nv_write_out && stat_r[BIT_BUSY] && !stat_r[BIT_WEL];
  endproperty
  a_soft_accept: assert property (p_soft_accept)
    else $error("status write not taken in software mode");

  property p_lock_sticky;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (load_r == LOAD_DONE) |=>
        ((stat_r & LOCK_MASK & $past(stat_r)) == ($past(stat_r) & LOCK_MASK));
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("security lock bit cleared");

  property p_suspend;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      take && stat_r[BIT_BUSY] && (cmd_code_in == CMD_SUSPEND)
      |=> stat_r[BIT_PAUSED] && !stat_r[BIT_BUSY];
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("suspend did not set paused flag");

  property p_protected_ignored;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      idle_take && is_array_op && hits_prot
      |=> cmd_refused_out && !op_start_out && ($stable(stat_r[BIT_WEL]));
  endproperty
  a_protected_ignored: assert property (p_protected_ignored)
    else $error("program or erase on protected region started");

  property p_busy_done;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      stat_r[BIT_BUSY] && op_done_in && !cmd_valid_in |=> !stat_r[BIT_BUSY];
  endproperty
  a_busy_done: assert property (p_busy_done)
    else $error("busy not cleared on completion");

  property p_hw_open;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wsr_try ##0 (guard == GUARD_HARDWARE) && stat_r[BIT_WEL] &&
      (write_protect_n_in || stat_r[BIT_QUAD]) |=> nv_write_out;
  endproperty
  a_hw_open: assert property (p_hw_open)
    else $error("status write refused with guard pin high");

  property p_otp_guard;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wsr_try ##0 (guard == GUARD_OTP) |=> cmd_refused_out && !nv_write_out;
  endproperty
  a_otp_guard: assert property (p_otp_guard)
    else $error("status write accepted in one-time guard mode");

endmodule // flash_status_write_protect

`default_nettype wire

/* tb/flash_host_model.sv */
// Behavioural host controller that issues decoded flash instructions.
`timescale 1ns/1ps
`default_nettype none

module flash_host_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        slow_in,
  input  wire logic        busy_in,
  output logic             cmd_valid_out,
  output logic [7:0]       cmd_code_out,
  output logic [23:0]      cmd_addr_out,
  output logic [15:0]      cmd_wdata_out,
  output logic             op_done_out
);
  int cnt = 0;

  initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out  = 8'h00;
    cmd_addr_out  = 24'h000000;
    cmd_wdata_out = 16'h0000;
    op_done_out   = 1'b0;
  end

  // Fields carry the inverse of the last value once released.
  task automatic issue(input logic [7:0] c, input logic [23:0] a,
                       input logic [15:0] d);
    @(negedge clk_in);
    cmd_valid_out = 1'b1;
    cmd_code_out  = c;
    cmd_addr_out  = a;
    cmd_wdata_out = d;
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    cmd_code_out  = ~c;
    cmd_addr_out  = ~a;
    cmd_wdata_out = ~d;
  endtask

  // The array finishes an operation after a short or a long busy time.
  always @(negedge clk_in) begin
    if (!rst_n_in || op_done_out) begin
      op_done_out <= 1'b0;
      cnt         <= 0;
    end else if (busy_in) begin
      if (cnt >= (slow_in ? 12 : 1)) begin
        op_done_out <= 1'b1;
        cnt         <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule // flash_host_model

`default_nettype wire

/* tb/flash_status_write_protect_test.sv */
// Self-checking bench for the flash status and protection block.
`timescale 1ns/1ps
`default_nettype none

module flash_status_write_protect_test;
  import flash_status_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic [15:0] nv_image   = 16'h0000;
  logic        wp_n       = 1'b1;
  logic        slow       = 1'b0;
  logic        cmd_valid, op_done, op_start, refused, nv_write, quad, p_any;
  logic [7:0]  cmd_code, st_lo, st_hi;
  logic [23:0] cmd_addr, a;
  logic [15:0] cmd_wdata, nv_data, st;
  logic [22:0] p_lo, p_hi;
  logic [7:0]  ops [7] = '{CMD_PAGE_PROG, CMD_QUAD_PROG, CMD_ERASE_4K,
    CMD_ERASE_32K, CMD_ERASE_64K, CMD_CHIP_ER_A, CMD_CHIP_ER_B};
  int          n_fail    = 0;
  int          tests_run = 0;
  integer      seed      = 32'h0463;

  always #5 clk_sys_in = ~clk_sys_in;

  flash_host_model host (.clk_in(clk_sys_in), .rst_n_in(rst_n_in),
    .slow_in(slow), .busy_in(st_lo[0]), .cmd_valid_out(cmd_valid),
    .cmd_code_out(cmd_code), .cmd_addr_out(cmd_addr),
    .cmd_wdata_out(cmd_wdata), .op_done_out(op_done));

  flash_status_write_protect dut (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .nv_image_in(nv_image), .cmd_valid_in(cmd_valid),
    .cmd_code_in(cmd_code), .cmd_addr_in(cmd_addr),
    .cmd_wdata_in(cmd_wdata), .op_done_in(op_done),
    .write_protect_n_in(wp_n), .status_low_byte_out(st_lo),
    .status_high_byte_out(st_hi), .op_start_out(op_start),
    .cmd_refused_out(refused), .nv_write_out(nv_write),
    .nv_data_out(nv_data), .quad_mode_out(quad), .prot_any_out(p_any),
    .prot_lo_out(p_lo), .prot_hi_out(p_hi));

  // ---------------------------------------------------------------------
  // Checking and reporting
  // ---------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (st_lo[0] !== 1'b0 && k < 60) begin
      @(negedge clk_sys_in);
      k++;
    end
    if (k >= 60) begin
      chk("busy_timeout", 1'b0, st_lo[0]);
      tally_and_finish();
    end else begin
      @(negedge clk_sys_in);
    end
  endtask

  // Expected range as {lo, hi} for m = {sec, tb, range}.
  function automatic logic [47:0] exp_rng(input logic [4:0] m);
    logic [23:0] sz;
    if (m[2:0] == 3'h7) return {24'h000000, 24'h7FFFFF};
    if (m[4]) sz = m[2] ? 24'h008000 : (24'h001000 << (m[1:0] - 2'h1));
    else sz = 24'h010000 << m[2:0];
    if (m[3]) return {24'h000000, sz - 24'h000001};
    return {ARRAY_BYTES - sz, 24'h7FFFFF};
  endfunction

  task automatic chk_prot(input logic [4:0] m, input logic cm);
    logic        any;
    logic [47:0] r;
    any = cm ? (m[2:0] != 3'h7) : (m[2:0] != 3'h0);
    if (cm && m[2:0] == 3'h0) m[2:0] = 3'h7;
    r = exp_rng(m);
    // A partial region under complement leaves the rest of the array.
    if (cm && m[2:0] != 3'h7) begin
      r = m[3] ? {r[23:0] + 24'h000001, 24'h7FFFFF} :
                 {24'h000000, r[47:24] - 24'h000001};
    end
    chk("prot_any", any, p_any);
    if (any) begin
      chk("prot_lo", r[46:24], p_lo);
      chk("prot_hi", r[22:0], p_hi);
    end
  endtask

  task automatic power_cycle(input int n);
    nv_image = st;
    rst_n_in = 1'b0;
    repeat (n) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    st = st & NV_MASK;
    if (st[8:7] == 2'h2) st[8] = 1'b0;
    chk("status", st, {st_hi, st_lo});
  endtask

  task automatic wrsr(input logic [15:0] d, input logic ok);
    logic [15:0] e;
    e = (d & NV_MASK) | (st & LOCK_MASK);
    host.issue(CMD_WREN, 24'h000000, 16'h0000);
    host.issue(CMD_WRSR, 24'h000000, d);
    chk("nv_write", ok, nv_write);
    chk("refused", !ok, refused);
    if (ok) begin
      chk("status", e | 16'h0001, {st_hi, st_lo});
      chk("nv_data", e, nv_data);
      st = e;
      wait_idle();
    end else begin
      chk("status", st, {st_hi, st_lo} & 16'hFFFD);
      host.issue(CMD_WRDI, 24'h000000, 16'h0000);
    end
  endtask

  task automatic pr(input logic [7:0] c, input logic [23:0] ad,
                    input logic ok);
    host.issue(CMD_WREN, 24'h000000, 16'h0000);
    host.issue(c, ad, 16'h0000);
    chk("op_start", ok, op_start);
    chk("refused", !ok, refused);
    chk("latch", !ok, st_lo[1]);
    chk("busy", ok, st_lo[0]);
    if (ok) wait_idle();
    else host.issue(CMD_WRDI, 24'h000000, 16'h0000);
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    st = 16'h0507;
    power_cycle(6);
    chk_prot(5'h01, 1'b0);
    chk("quad", 1'b0, quad);
    host.issue(CMD_WRSR, 24'h000000, 16'h0010);
    chk("refused", 1'b1, refused);
    chk("status", st, {st_hi, st_lo});
    host.issue(CMD_WREN, 24'h000000, 16'h0000);
    chk("latch", 1'b1, st_lo[1]);
    host.issue(CMD_WRDI, 24'h000000, 16'h0000);
    chk("latch", 1'b0, st_lo[1]);
    for (int i = 0; i < 32; i++) begin
      wp_n = 1'($random(seed));
      wrsr({8'h00, 1'b0, i[4:0], 2'h0}, 1'b1);
      chk_prot(i[4:0], 1'b0);
    end
    wp_n = 1'b1;
    wrsr(16'h4000, 1'b1);
    chk_prot(5'h00, 1'b1);
    wrsr(16'h401C, 1'b1);
    chk_prot(5'h07, 1'b1);
    wrsr(16'h4004, 1'b1);
    chk_prot(5'h01, 1'b1);
    wrsr(16'h4064, 1'b1);
    chk_prot(5'h19, 1'b1);
    wrsr(16'h0004, 1'b1);
    for (int i = 0; i < 7; i++) pr(ops[i], 24'h000000, i < 5);
    pr(CMD_PAGE_PROG, 24'h7DFFFF, 1'b1);
    pr(CMD_ERASE_64K, 24'h7EFFFF, 1'b0);
    for (int i = 0; i < 16; i++) begin
      a = {1'b0, 23'($random(seed))};
      pr(CMD_PAGE_PROG, a, a < 24'h7E0000);
    end
    slow = 1'b1;
    host.issue(CMD_WREN, 24'h000000, 16'h0000);
    host.issue(CMD_PAGE_PROG, 24'h000000, 16'h0000);
    host.issue(CMD_WREN, 24'h000000, 16'h0000);
    chk("latch", 1'b0, st_lo[1]);
    host.issue(CMD_SUSPEND, 24'h000000, 16'h0000);
    chk("paused", 1'b1, st_hi[7]);
    chk("busy", 1'b0, st_lo[0]);
    host.issue(CMD_RESUME, 24'h000000, 16'h0000);
    chk("paused", 1'b0, st_hi[7]);
    chk("busy", 1'b1, st_lo[0]);
    wait_idle();
    slow = 1'b0;
    wrsr(16'h0080, 1'b1);
    wp_n = 1'b0;
    wrsr(16'h0084, 1'b0);
    wp_n = 1'b1;
    wrsr(16'h0100, 1'b1);
    wrsr(16'h0000, 1'b0);
    power_cycle(2);
    wrsr(16'h0280, 1'b1);
    chk("quad", 1'b1, quad);
    wp_n = 1'b0;
    wrsr(16'h0284, 1'b1);
    wp_n = 1'b1;
    wrsr(16'h0800, 1'b1);
    wrsr(16'h0000, 1'b1);
    chk("lock", 1'b1, st_hi[3]);
    pr(CMD_SEC_PROG, 24'h001000, 1'b0);
    pr(CMD_SEC_PROG, 24'h002000, 1'b1);
    pr(CMD_SEC_ERASE, 24'h003000, 1'b1);
    pr(CMD_SEC_ERASE, 24'h000000, 1'b0);
    wrsr(16'h0180, 1'b1);
    wrsr(16'h0000, 1'b0);
    tally_and_finish();
  end
endmodule // flash_status_write_protect_test

`default_nettype wire
